// file: bit_flag_pkg.sv
// constants, op codes and helpers shared by the bit, flag and shift execution unit
// Overview of operation
// - rotate left through carry: old carry into bit 0, bit 7 to carry, one cycle
// - rotate right through carry: old carry into bit 7, bit 0 to carry, one cycle
// - io bit set forces one io register bit high, flags untouched, two cycles
// - io bit clear forces one io register bit low, flags untouched, two cycles
// - bit to transfer flag copies one register bit into T only, one cycle
// - transfer flag to bit copies T into one register bit, flags untouched
// - overflow set and clear change only V, one cycle
// - half carry set and clear change only H, one cycle
// - signed flag set and clear change only S, one cycle
// - nonvolatile memory path adds at least one cycle, more while it stalls
// - data access into the lowest 64 io bytes adds one cycle
// - watchdog kick takes one cycle, no flags, pulses watchdog restart
// - sleep takes one cycle, no flags, requests the selected sleep mode
// - break takes one cycle, no flags, notifies the debug logic
package bit_flag_pkg;

    localparam int unsigned ADDR_W = 8;
    localparam int unsigned IO_REGS = 32;

    // register byte offsets
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OPERAND = 8'h04;
    localparam logic [7:0] ADDR_FLAGS = 8'h08;
    localparam logic [7:0] ADDR_ACCESS = 8'h0C;
    localparam logic [7:0] ADDR_STATE = 8'h10;
    localparam logic [7:0] ADDR_CYCLES = 8'h14;
    localparam int unsigned IO_SEL_BIT = 7;

    // control word fields
    localparam int unsigned CTRL_OP_LSB = 0;
    localparam int unsigned CTRL_BIT_LSB = 8;
    localparam int unsigned CTRL_IO_LSB = 16;
    localparam int unsigned CTRL_SLEEP_LSB = 24;

    // access word fields
    localparam int unsigned ACC_ADDR_LSB = 0;
    localparam int unsigned ACC_BASE_LSB = 16;
    localparam int unsigned ACC_BASE_W = 4;
    localparam int unsigned ACC_NVM_BIT = 20;

    // state word fields
    localparam int unsigned STATE_BUSY_BIT = 0;
    localparam int unsigned STATE_FSM_LSB = 1;
    localparam int unsigned STATE_ERR_BIT = 8;

    // status flag positions
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_S = 3'h4;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;
    localparam logic [2:0] FLAG_I = 3'h7;

    // reset values
    localparam logic [7:0] FLAGS_RST = 8'h00;
    localparam logic [7:0] OPERAND_RST = 8'h00;
    localparam logic [31:0] ACCESS_RST = 32'h0001_0000;

    // cycle counts
    localparam logic [1:0] CYC_SINGLE = 2'h1;
    localparam logic [1:0] CYC_IO_BIT = 2'h2;
    localparam logic [4:0] CYC_NVM_EXTRA = 5'h01;
    localparam logic [4:0] CYC_LOW_IO_EXTRA = 5'h01;
    localparam logic [4:0] CYC_BASE_MIN = 5'h01;

    // data space window of the low io registers
    localparam logic [15:0] IO_DATA_BASE = 16'h0020;
    localparam logic [15:0] LOW_IO_BYTES = 16'h0040;
    localparam logic [15:0] LOW_IO_END = IO_DATA_BASE + LOW_IO_BYTES;

    // codes 0x10..0x1F are the named flag forms: bits 3:1 flag index, bit 0 set clear
    typedef enum logic [5:0] {
        OP_NOP = 6'h00,
        OP_LOGICAL_SHIFT_LEFT = 6'h01,
        OP_LOGICAL_SHIFT_RIGHT = 6'h02,
        OP_ROTATE_LEFT_CARRY = 6'h03,
        OP_ROTATE_RIGHT_CARRY = 6'h04,
        OP_ARITH_SHIFT_RIGHT = 6'h05,
        OP_NIBBLE_SWAP = 6'h06,
        OP_IO_BIT_SET = 6'h07,
        OP_IO_BIT_CLEAR = 6'h08,
        OP_BIT_TO_TRANSFER_FLAG = 6'h09,
        OP_TRANSFER_FLAG_TO_BIT = 6'h0A,
        OP_GENERIC_FLAG_SET = 6'h0B,
        OP_GENERIC_FLAG_CLEAR = 6'h0C,
        OP_DATA_ACCESS = 6'h0D,
        OP_WATCHDOG_KICK = 6'h0E,
        OP_SLEEP = 6'h0F,
        OP_CARRY_FLAG_SET = 6'h10,
        OP_CARRY_FLAG_CLEAR = 6'h11,
        OP_ZERO_FLAG_SET = 6'h12,
        OP_ZERO_FLAG_CLEAR = 6'h13,
        OP_NEGATIVE_FLAG_SET = 6'h14,
        OP_NEGATIVE_FLAG_CLEAR = 6'h15,
        OP_OVERFLOW_FLAG_SET = 6'h16,
        OP_OVERFLOW_FLAG_CLEAR = 6'h17,
        OP_SIGNED_FLAG_SET = 6'h18,
        OP_SIGNED_FLAG_CLEAR = 6'h19,
        OP_HALF_CARRY_SET = 6'h1A,
        OP_HALF_CARRY_CLEAR = 6'h1B,
        OP_TRANSFER_FLAG_SET = 6'h1C,
        OP_TRANSFER_FLAG_CLEAR = 6'h1D,
        OP_GLOBAL_IRQ_ON = 6'h1E,
        OP_GLOBAL_IRQ_OFF = 6'h1F,
        OP_BREAK = 6'h20
    } op_e;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_RUN = 2'b01,
        ST_ACCESS = 2'b11
    } state_e;

    function automatic logic [7:0] put_bit(logic [7:0] value, logic [2:0] idx, logic b);
        logic [7:0] v;
        v = value;
        v[idx] = b;
        return v;
    endfunction : put_bit

    function automatic logic [1:0] op_cycles(logic [5:0] op);
        return (op == OP_IO_BIT_SET || op == OP_IO_BIT_CLEAR) ? CYC_IO_BIT : CYC_SINGLE;
    endfunction : op_cycles

endpackage : bit_flag_pkg

// file: shift_unit.sv
// combinational shift, rotate and nibble swap, with flag updates for the shifts and rotates only
`timescale 1ns/10ps
module shift_unit (
    input wire bit_flag_pkg::op_e op,
    input wire logic [7:0] value,
    input wire logic [7:0] flags_in,
    output logic [7:0] result,
    output logic [7:0] flags_out
);
    import bit_flag_pkg::*;

    logic carry;
    logic neg;
    logic shifting;

    always_comb begin
        result = value;
        carry = flags_in[FLAG_C];
        shifting = 1'b1;
        unique case (op)
            OP_LOGICAL_SHIFT_LEFT: {carry, result} = {value, 1'b0};
            OP_LOGICAL_SHIFT_RIGHT: {result, carry} = {1'b0, value};
            OP_ROTATE_LEFT_CARRY: {carry, result} = {value, flags_in[FLAG_C]};
            OP_ROTATE_RIGHT_CARRY: {result, carry} = {flags_in[FLAG_C], value};
            OP_ARITH_SHIFT_RIGHT: {result, carry} = {value[7], value};
            OP_NIBBLE_SWAP: begin
                result = {value[3:0], value[7:4]};
                shifting = 1'b0;
            end
            default: shifting = 1'b0;
        endcase
    end

    assign neg = result[7];

    // the signed flag is left alone here; only the flags the shifts name are updated
    always_comb begin
        flags_out = flags_in;
        if (shifting) begin
            flags_out[FLAG_C] = carry;
            flags_out[FLAG_Z] = (result == 8'h00);
            flags_out[FLAG_N] = neg;
            flags_out[FLAG_V] = neg ^ carry;
        end
        if (op == OP_LOGICAL_SHIFT_LEFT || op == OP_ROTATE_LEFT_CARRY) begin
            flags_out[FLAG_H] = value[3];
        end
    end

endmodule : shift_unit

// file: access_timer.sv
// stretches a data access by the low io and nonvolatile memory penalties
`timescale 1ns/10ps
module access_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [bit_flag_pkg::ACC_BASE_W-1:0] base_cycles,
    input wire logic [15:0] data_addr,
    input wire logic nvm_path,
    input wire logic nvm_stall,
    output logic busy,
    output logic done
);
    import bit_flag_pkg::*;

    logic [4:0] remaining;
    wire low_io = (data_addr >= IO_DATA_BASE) && (data_addr < LOW_IO_END);
    wire [4:0] base_ext = {1'b0, base_cycles};
    wire [4:0] base_fix = (base_ext == 5'h00) ? CYC_BASE_MIN : base_ext;
    wire [4:0] io_extra = low_io ? CYC_LOW_IO_EXTRA : 5'h00;
    wire [4:0] nvm_extra = nvm_path ? CYC_NVM_EXTRA : 5'h00;
    wire [4:0] total = base_fix + io_extra + nvm_extra;
    // a busy controller holds the final cycle for as long as it stalls
    wire hold = nvm_path && nvm_stall && (remaining == 5'h01);

    assign busy = (remaining != 5'h00);
    assign done = busy && (remaining == 5'h01) && !hold;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            remaining <= 5'h00;
        end else if (start) begin
            remaining <= total;
        end else if (busy && !hold) begin
            remaining <= remaining - 5'h01;
        end
    end

endmodule : access_timer

// file: bit_flag_shift_unit.sv
// bit, flag, shift and core control execution unit with its apb register slave
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/10ps
module bit_flag_shift_unit (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [bit_flag_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic nvm_stall,
    output logic watchdog_restart,
    output logic sleep_request,
    output logic [2:0] sleep_mode,
    output logic debug_break,
    output logic global_irq_enable,
    output logic op_done
);
    import bit_flag_pkg::*;

    state_e state;
    state_e next_state;
    op_e op_q;
    logic [2:0] bit_q;
    logic [4:0] io_q;
    logic [2:0] sleep_sel;
    logic [1:0] cnt;
    logic [7:0] operand;
    logic [7:0] flags;
    logic [31:0] access_cfg;
    logic [15:0] cyc_run;
    logic err_sticky;
    logic [7:0] io_file [0:IO_REGS-1];

    // apb decode
    wire setup = psel && !penable;
    wire wr_fire = psel && penable && pwrite && pready;
    wire aligned = (paddr[1:0] == 2'b00);
    wire hit_io = paddr[IO_SEL_BIT] && aligned;
    wire [4:0] io_idx = paddr[6:2];
    wire hit_ctrl = (paddr == ADDR_CTRL);
    wire hit_operand = (paddr == ADDR_OPERAND);
    wire hit_flags = (paddr == ADDR_FLAGS);
    wire hit_access = (paddr == ADDR_ACCESS);
    wire hit_state = (paddr == ADDR_STATE);
    wire hit_cycles = (paddr == ADDR_CYCLES);
    wire mapped = hit_io || hit_ctrl || hit_operand || hit_flags || hit_access
        || hit_state || hit_cycles;

    // command decode from the write data
    wire [5:0] wr_op = pwdata[CTRL_OP_LSB +: 6];
    wire op_legal = (wr_op <= OP_BREAK);
    wire idle = (state == ST_IDLE);
    wire ctrl_refused = pwrite && hit_ctrl && !(op_legal && idle);

    // a refused command is answered with pslverr and never starts
    wire start = wr_fire && hit_ctrl && !pslverr;
    wire start_access = start && (wr_op == OP_DATA_ACCESS);
    wire refused_fire = wr_fire && hit_ctrl && pslverr;

    // execution decode
    wire commit = (state == ST_RUN) && (cnt == 2'h0);
    wire acc_done;
    wire named = (op_q[5:4] == 2'b01) && (op_q != OP_BREAK);
    wire [2:0] named_idx = op_q[3:1];
    wire named_val = !op_q[0];
    wire io_op = (op_q == OP_IO_BIT_SET) || (op_q == OP_IO_BIT_CLEAR);
    wire io_val = (op_q == OP_IO_BIT_SET);

    logic [7:0] sh_result;
    logic [7:0] sh_flags;

    shift_unit u_shift (
        .op(op_q),
        .value(operand),
        .flags_in(flags),
        .result(sh_result),
        .flags_out(sh_flags)
    );

    access_timer u_access (
        .pclk(pclk),
        .presetn(presetn),
        .start(start_access),
        .base_cycles(access_cfg[ACC_BASE_LSB +: ACC_BASE_W]),
        .data_addr(access_cfg[ACC_ADDR_LSB +: 16]),
        .nvm_path(access_cfg[ACC_NVM_BIT]),
        .nvm_stall(nvm_stall),
        .busy(),
        .done(acc_done)
    );

    // each set or clear writes exactly one flag, bit to transfer flag writes T; everything else keeps the shift result
    wire [7:0] generic_flags = put_bit(flags, bit_q, op_q == OP_GENERIC_FLAG_SET);
    wire [7:0] named_flags = put_bit(flags, named_idx, named_val);
    wire [7:0] store_flags = put_bit(flags, FLAG_T, operand[bit_q]);
    wire generic = (op_q == OP_GENERIC_FLAG_SET) || (op_q == OP_GENERIC_FLAG_CLEAR);

    wire [7:0] next_flags =
        (op_q == OP_BIT_TO_TRANSFER_FLAG) ? store_flags :
        generic ? generic_flags :
        named ? named_flags :
        sh_flags;

    wire [7:0] next_operand = (op_q == OP_TRANSFER_FLAG_TO_BIT) ?
        put_bit(operand, bit_q, flags[FLAG_T]) : sh_result;

    // read mux
    wire [31:0] ctrl_word = {5'h00, sleep_sel, 3'h0, io_q, 5'h00, bit_q, 2'h0, op_q};
    wire [31:0] state_word = {23'h0, err_sticky, 5'h00, state, !idle};
    wire [31:0] rd_word =
        hit_io ? {24'h0, io_file[io_idx]} :
        hit_ctrl ? ctrl_word :
        hit_operand ? {24'h0, operand} :
        hit_flags ? {24'h0, flags} :
        hit_access ? access_cfg :
        hit_state ? state_word :
        hit_cycles ? {16'h0, cyc_run} :
        32'h0;

    always_comb begin
        next_state = state;
        unique case (state)
            ST_IDLE: begin
                if (start) begin
                    next_state = (wr_op == OP_DATA_ACCESS) ? ST_ACCESS : ST_RUN;
                end
            end
            ST_RUN: begin
                if (cnt == 2'h0) begin
                    next_state = ST_IDLE;
                end
            end
            ST_ACCESS: begin
                if (acc_done) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // apb answer: one wait-free access phase after every setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            pready <= setup;
            pslverr <= setup && (!mapped || ctrl_refused);
            prdata <= setup ? rd_word : 32'h0;
        end
    end

    // command capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            op_q <= OP_NOP;
            bit_q <= 3'h0;
            io_q <= 5'h00;
            sleep_sel <= 3'h0;
            cnt <= 2'h0;
        end else if (start) begin
            op_q <= op_e'(wr_op);
            bit_q <= pwdata[CTRL_BIT_LSB +: 3];
            io_q <= pwdata[CTRL_IO_LSB +: 5];
            sleep_sel <= pwdata[CTRL_SLEEP_LSB +: 3];
            cnt <= op_cycles(wr_op) - CYC_SINGLE;
        end else if (state == ST_RUN && cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end
    end

    // execution results win over a software write landing in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            operand <= OPERAND_RST;
        end else if (commit) begin
            operand <= next_operand;
        end else if (wr_fire && hit_operand) begin
            operand <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flags <= FLAGS_RST;
        end else if (commit) begin
            flags <= next_flags;
        end else if (wr_fire && hit_flags) begin
            flags <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            access_cfg <= ACCESS_RST;
        end else if (wr_fire && hit_access) begin
            access_cfg <= pwdata;
        end
    end

    // io registers; the bit operations touch one bit only and never the flags
    for (genvar i = 0; i < IO_REGS; i++) begin : g_io
        wire sel_exec = commit && io_op && (io_q == 5'(i));
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                io_file[i] <= 8'h00;
            end else if (sel_exec) begin
                io_file[i] <= put_bit(io_file[i], bit_q, io_val);
            end else if (wr_fire && hit_io && io_idx == 5'(i)) begin
                io_file[i] <= pwdata[7:0];
            end
        end
    end

    // cycles spent by the current or most recent command
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cyc_run <= 16'h0000;
        end else if (start) begin
            cyc_run <= 16'h0000;
        end else if (!idle && cyc_run != 16'hFFFF) begin
            cyc_run <= cyc_run + 16'h0001;
        end
    end

    // refused command sticks until written one; a new refusal beats the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_sticky <= 1'b0;
        end else if (refused_fire) begin
            err_sticky <= 1'b1;
        end else if (wr_fire && hit_state && pwdata[STATE_ERR_BIT]) begin
            err_sticky <= 1'b0;
        end
    end

    // core control requests are single pulses in the cycle after commit, alongside op_done
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_restart <= 1'b0;
            sleep_request <= 1'b0;
            sleep_mode <= 3'h0;
            debug_break <= 1'b0;
            op_done <= 1'b0;
        end else begin
            watchdog_restart <= commit && (op_q == OP_WATCHDOG_KICK);
            sleep_request <= commit && (op_q == OP_SLEEP);
            debug_break <= commit && (op_q == OP_BREAK);
            op_done <= commit || acc_done;
            if (commit && op_q == OP_SLEEP) begin
                sleep_mode <= sleep_sel;
            end
        end
    end

    assign global_irq_enable = flags[FLAG_I];

endmodule : bit_flag_shift_unit

// file: bit_flag_shift_unit_assertions.sv
// port level assertions for the bit, flag and shift unit
`timescale 1ns/10ps
module bit_flag_shift_unit_assertions (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic nvm_stall,
    input wire logic watchdog_restart,
    input wire logic sleep_request,
    input wire logic [2:0] sleep_mode,
    input wire logic debug_break,
    input wire logic global_irq_enable,
    input wire logic op_done
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    // an accepted command write, seen at its access edge
    wire logic go = psel && penable && pready && pwrite && paddr == 8'h00 && !pslverr;
    wire logic [5:0] op = pwdata[5:0];
    wire logic single = go && !(op inside {6'h07, 6'h08, 6'h0D});

    property p_sleep;
        logic [2:0] m;
        (go && op == 6'h0F, m = pwdata[26:24]) |-> ##2 sleep_request && sleep_mode == m;
    endproperty

    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_err_with_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    a_unmapped_err: assert property (psel && !penable && paddr inside {[8'h18:8'h7C]}
        |=> pslverr && prdata == 32'h0) else $error("unmapped not refused");
    a_single_done: assert property (
        single |-> ##1 !op_done ##1 op_done)
        else $error("single op latency wrong");
    a_io_bit_done: assert property (
        go && op inside {6'h07, 6'h08} |-> ##1 !op_done [*2] ##1 op_done)
        else $error("io bit op latency wrong");
    a_kick_pulse: assert property (go && op == 6'h0E |-> ##2 watchdog_restart ##1 !watchdog_restart)
        else $error("watchdog pulse wrong");
    a_sleep_mode: assert property (p_sleep)
        else $error("sleep request wrong");
    a_break_pulse: assert property (go && op == 6'h20 |-> ##2 debug_break)
        else $error("break pulse missing");
    a_irq_on: assert property (go && op == 6'h1E |-> ##2 global_irq_enable)
        else $error("irq enable not set");
    a_pulse_with_done: assert property (
        watchdog_restart || sleep_request || debug_break |-> op_done)
        else $error("pulse outside completion");

    c_rotate: cover property (go && op == 6'h03);
    c_io_set: cover property (go && op == 6'h07);
    c_refused: cover property (pslverr);
endmodule : bit_flag_shift_unit_assertions

// file: tb_bit_flag_shift_unit.sv
// self-checking testbench for the bit, flag and shift unit
`timescale 1ns/10ps
module tb_bit_flag_shift_unit;
    logic pclk, presetn, psel, penable, pwrite, nvm_stall;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic pready, pslverr, watchdog_restart, sleep_request, debug_break;
    logic global_irq_enable, op_done, serr;
    logic [2:0] sleep_mode, pulses;
    int err_total = 0;
    int checked = 0;
    int cyc = 0;
    int lat;

    bit_flag_shift_unit DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .nvm_stall(nvm_stall), .watchdog_restart(watchdog_restart),
        .sleep_request(sleep_request), .sleep_mode(sleep_mode), .debug_break(debug_break),
        .global_irq_enable(global_irq_enable), .op_done(op_done)
    );

    task automatic print_verdict();
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : print_verdict

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // entered just after a rising edge; holds the request until ready is sampled,
    // then lets one idle edge pass so the next call never re-drives psel in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, e);
    endtask : rd

    // lat counts edges from the accepting edge to the one that sees op_done
    task automatic wait_done();
        while (op_done !== 1'b1 && lat < 60) begin
            @(posedge pclk);
            lat++;
            pulses = {debug_break, sleep_request, watchdog_restart};
        end
    endtask : wait_done

    // apb returns one edge after the accepting edge, so lat starts at one
    task automatic cmd(input logic [31:0] w);
        apb(1'b1, 8'h00, w);
        lat = 1;
        wait_done();
    endtask : cmd

    function automatic logic [15:0] shf(input logic [5:0] op, input logic [7:0] v,
                                        input logic [7:0] f);
        logic [7:0] r;
        logic [7:0] g;
        logic c;
        g = f;
        case (op)
            6'h01: r = {v[6:0], 1'b0};
            6'h02: r = {1'b0, v[7:1]};
            6'h03: r = {v[6:0], f[0]};
            6'h04: r = {f[0], v[7:1]};
            6'h05: r = {v[7], v[7:1]};
            default: r = {v[3:0], v[7:4]};
        endcase
        if (op == 6'h06) return {r, f};
        c = (op == 6'h01 || op == 6'h03) ? v[7] : v[0];
        g[0] = c;
        g[1] = (r == 8'h00);
        g[2] = r[7];
        g[3] = r[7] ^ c;
        if (op == 6'h01 || op == 6'h03) g[5] = v[3];
        return {r, g};
    endfunction : shf

    task automatic t_shift();
        logic [7:0] vals [3] = '{8'h81, 8'h08, 8'h00};
        logic [15:0] e;
        for (int o = 1; o <= 6; o++) begin
            for (int k = 0; k < 3; k++) begin
                apb(1'b1, 8'h04, {24'h0, vals[k]});
                apb(1'b1, 8'h08, {24'h0, 7'h28, k[0]});
                cmd(32'(o));
                e = shf(o[5:0], vals[k], {7'h28, k[0]});
                rd(8'h04, {24'h0, e[15:8]});
                rd(8'h08, {24'h0, e[7:0]});
                chk(32'(lat), 32'd2);
            end
        end
    endtask : t_shift

    task automatic t_bits();
        apb(1'b1, 8'h04, 32'h20);
        apb(1'b1, 8'h08, 32'h00);
        cmd(32'h0000_0509);
        rd(8'h08, 32'h40);
        cmd(32'h0000_020A);
        rd(8'h04, 32'h24);
        rd(8'h08, 32'h40);
        cmd(32'h0000_0009);
        rd(8'h08, 32'h00);
    endtask : t_bits

    task automatic t_flags();
        logic [7:0] f;
        for (int o = 16; o < 32; o++) begin
            apb(1'b1, 8'h08, 32'h5A);
            cmd(32'(o));
            f = 8'h5A;
            f[(o - 16) >> 1] = !o[0];
            rd(8'h08, {24'h0, f});
            chk(global_irq_enable, f[7]);
        end
        for (int s = 0; s < 8; s++) begin
            apb(1'b1, 8'h08, 32'h00);
            cmd(32'h0B | (s << 8));
            rd(8'h08, 32'(1 << s));
            apb(1'b1, 8'h08, 32'hFF);
            cmd(32'h0C | (s << 8));
            rd(8'h08, 32'hFF ^ 32'(1 << s));
        end
    endtask : t_flags

    task automatic t_io();
        apb(1'b1, 8'h8C, 32'hA5);
        apb(1'b1, 8'h08, 32'h3C);
        cmd(32'h0003_0107);
        chk(32'(lat), 32'd3);
        rd(8'h8C, 32'hA7);
        cmd(32'h0003_0708);
        chk(32'(lat), 32'd3);
        rd(8'h8C, 32'h27);
        cmd(32'h001F_0007);
        rd(8'hFC, 32'h01);
        rd(8'h08, 32'h3C);
    endtask : t_io

    task automatic t_ctrl();
        cmd(32'h0E);
        chk(pulses, 3'b001);
        cmd(32'h0500_000F);
        chk(pulses, 3'b010);
        chk(sleep_mode, 3'h5);
        cmd(32'h20);
        chk(pulses, 3'b100);
        chk(32'(lat), 32'd2);
        rd(8'h08, 32'h3C);
    endtask : t_ctrl

    task automatic t_access();
        logic [31:0] acc [7] = '{32'h0002_0100, 32'h0002_0020, 32'h0000_005F, 32'h0001_0060,
                                 32'h0001_001F, 32'h0012_0100, 32'h0013_0040};
        int el [7] = '{3, 4, 3, 2, 2, 4, 6};
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, 8'h0C, acc[i]);
            cmd(32'h0D);
            chk(32'(lat), 32'(el[i]));
        end
        // a held stall must stretch the final cycle until released
        nvm_stall <= 1'b1;
        apb(1'b1, 8'h0C, 32'h0012_0100);
        apb(1'b1, 8'h00, 32'h0D);
        lat = 1;
        repeat (5) @(posedge pclk);
        lat = 6;
        nvm_stall <= 1'b0;
        wait_done();
        chk(32'(lat), 32'd8);
    endtask : t_access

    task automatic t_refuse();
        apb(1'b0, 8'h18, 32'h0);
        chk({serr, rdat}, {1'b1, 32'h0});
        apb(1'b1, 8'h00, 32'h21);
        chk(serr, 1'b1);
        rd(8'h10, 32'h100);
        apb(1'b1, 8'h10, 32'h100);
        rd(8'h10, 32'h0);
        apb(1'b1, 8'h0C, 32'h000F_0100);
        apb(1'b1, 8'h00, 32'h0D);
        apb(1'b1, 8'h00, 32'h0E);
        chk(serr, 1'b1);
        lat = 0;
        wait_done();
        rd(8'h10, 32'h100);
    endtask : t_refuse

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 30000) begin
            err_total++;
            print_verdict();
        end
    end

    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, nvm_stall} = 4'h0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(8'h08, 32'h0);
        rd(8'h04, 32'h0);
        rd(8'h0C, 32'h0001_0000);
        t_shift();
        t_bits();
        t_flags();
        t_io();
        t_ctrl();
        t_access();
        t_refuse();
        print_verdict();
    end
endmodule : tb_bit_flag_shift_unit

bind bit_flag_shift_unit bit_flag_shift_unit_assertions u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .nvm_stall(nvm_stall), .watchdog_restart(watchdog_restart),
    .sleep_request(sleep_request), .sleep_mode(sleep_mode), .debug_break(debug_break),
    .global_irq_enable(global_irq_enable), .op_done(op_done)
);
